// File: hdl/xmp_pkg.sv
// constants and types for the external data-memory port block
// assumes a single core clock and an apb register bus of 32-bit words

package xmp_pkg;

   // -------------------------------------------------------------------
   // register indices and byte addresses
   // -------------------------------------------------------------------
   localparam int unsigned ADDR_W = 12;

   localparam logic [7:0] IDX_DATA_POINTER_LOW    = 8'h82;
   localparam logic [7:0] IDX_DATA_POINTER_HIGH   = 8'h83;
   localparam logic [7:0] IDX_DATA_POINTER_PAGE   = 8'h84;
   localparam logic [7:0] IDX_EXTERNAL_WAIT_CYCLES = 8'h9f;

   localparam logic [ADDR_W-1:0] OFS_DATA_POINTER_LOW =
      {2'b00, IDX_DATA_POINTER_LOW, 2'b00};
   localparam logic [ADDR_W-1:0] OFS_DATA_POINTER_HIGH =
      {2'b00, IDX_DATA_POINTER_HIGH, 2'b00};
   localparam logic [ADDR_W-1:0] OFS_DATA_POINTER_PAGE =
      {2'b00, IDX_DATA_POINTER_PAGE, 2'b00};
   localparam logic [ADDR_W-1:0] OFS_EXTERNAL_WAIT_CYCLES =
      {2'b00, IDX_EXTERNAL_WAIT_CYCLES, 2'b00};

   localparam logic [ADDR_W-1:0] OFS_CONTROL    = 12'h000;
   localparam logic [ADDR_W-1:0] OFS_WRITE_DATA = 12'h004;
   localparam logic [ADDR_W-1:0] OFS_READ_DATA  = 12'h008;
   localparam logic [ADDR_W-1:0] OFS_STATUS     = 12'h00c;
   localparam logic [ADDR_W-1:0] OFS_TIMER      = 12'h010;
   localparam logic [ADDR_W-1:0] OFS_COMMAND    = 12'h014;

   // -------------------------------------------------------------------
   // reset values
   // -------------------------------------------------------------------
   localparam logic [7:0]  RST_POINTER = 8'h00;
   localparam logic [7:0]  RST_WAIT    = 8'h00;
   localparam logic [7:0]  RST_BYTE    = 8'h00;
   localparam logic [15:0] RST_TIMER   = 16'h0000;

   // -------------------------------------------------------------------
   // field positions
   // -------------------------------------------------------------------
   localparam int unsigned CTL_TIMER_RUN = 0;
   localparam int unsigned CMD_WRITE     = 0;
   localparam int unsigned CMD_GENERIC   = 1;
   localparam int unsigned CMD_LEN_LSB   = 4;
   localparam int unsigned CMD_LEN_W     = 3;
   localparam int unsigned STS_BUSY      = 0;
   localparam int unsigned STS_ALE       = 1;
   localparam int unsigned STS_LAST_WR   = 2;

   // -------------------------------------------------------------------
   // cycle counts
   // -------------------------------------------------------------------
   localparam int unsigned LEN_W = 9;
   localparam logic [LEN_W-1:0] MOVE_BASE_CYCLES = 9'h004;

   // -------------------------------------------------------------------
   // pin group of the external data-memory port
   // -------------------------------------------------------------------
   typedef struct packed {
      logic        ale;
      logic        rd_n;
      logic        wr_n;
      logic [23:0] addr;
      logic [7:0]  dout;
      logic        doe;
   } xmp_xport_type;

endpackage : xmp_pkg

// File: hdl/xmp_cycle_seq.sv
// machine-cycle sequencer: counts the cycles of one instruction and
// drives the address latch strobe from the cycle position
// assumes start is only meaningful while busy is low

`timescale 1ns/1ps
`default_nettype none

module xmp_cycle_seq
   import xmp_pkg::*;
(
   // clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // request
   input  wire logic             start,
   input  wire logic [LEN_W-1:0] length,
   // state
   output logic                  busy,
   output logic [LEN_W-1:0]      count,
   output logic [LEN_W-1:0]      len,
   output logic                  ale
);

   logic last;
   logic take;

   assign last = busy && (count == len - 9'h001);
   assign take = start && !busy;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy  <= 1'b0;
         count <= 9'h000;
         len   <= 9'h001;
      end else if (take) begin
         busy  <= 1'b1;
         count <= 9'h000;
         len   <= length;
      end else if (last) begin
         busy  <= 1'b0;
      end else if (busy) begin
         count <= count + 9'h001;
      end
   end

   // idle cycles count as single-cycle instructions, so ale rests high
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ale <= 1'b1;
      end else if (take) begin
         ale <= 1'b1;
      end else if (busy && !last) begin
         ale <= 1'b0;
      end else begin
         ale <= 1'b1;
      end
   end

endmodule : xmp_cycle_seq

`default_nettype wire

// File: hdl/xmp_tick_timer.sv
// 16-bit timer that advances on every core clock while run is high; a load takes priority
// assumes load and run come from logic on the same clock

`timescale 1ns/1ps
`default_nettype none

module xmp_tick_timer
   import xmp_pkg::*;
(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // control
   input  wire logic        run,
   input  wire logic        load,
   input  wire logic [15:0] load_value,
   // state
   output logic [15:0]      value
);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         value <= RST_TIMER;
      end else if (load) begin
         value <= load_value;
      end else if (run) begin
         value <= value + 16'h0001;
      end
   end

endmodule : xmp_tick_timer

`default_nettype wire

// File: hdl/xmp_ext_mem_port.sv
// external data-memory port with machine-cycle timing, apb registers
// assumes an apb master on pclk and a static ram on the port pins;
// the ram data bus arrives asynchronously and is synchronised here
//
// Local design decision: the APB slave port.

`timescale 1ns/1ps
`default_nettype none

module xmp_ext_mem_port
   import xmp_pkg::*;
(
   // apb slave
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   // external memory port
   output xmp_xport_type          xport,
   input  wire logic [7:0]        xdata_in
);

   // -------------------------------------------------------------------
   // declarations
   // -------------------------------------------------------------------
   logic [7:0]       data_pointer_low;
   logic [7:0]       data_pointer_high;
   logic [7:0]       data_pointer_page;
   logic [7:0]       external_wait_cycles;
   logic             timer_run;
   logic [7:0]       write_byte;
   logic [7:0]       read_byte;
   logic             last_write;

   logic             is_move;
   logic             is_write;
   logic [23:0]      addr_q;
   logic             rd_n_q;
   logic             wr_n_q;
   logic [7:0]       dout_q;
   logic             doe_q;

   logic [7:0]       xdata_meta;
   logic [7:0]       xdata_sync;

   logic             wr_access;
   logic             setup;
   logic             mapped;
   logic [31:0]      next_prdata;
   logic             cmd_write;
   logic             start;
   logic [LEN_W-1:0] start_len;
   logic [LEN_W-1:0] gen_len;
   logic             seq_busy;
   logic [LEN_W-1:0] seq_count;
   logic [LEN_W-1:0] seq_len;
   logic             seq_ale;
   logic             seq_last;
   logic             strobe_next;
   logic [15:0]      timer_value;
   logic             timer_load;

   // -------------------------------------------------------------------
   // apb decode
   // -------------------------------------------------------------------
   // zero wait states: the answer comes in the first access cycle
   assign pready    = 1'b1;
   assign setup     = psel && !penable;
   assign wr_access = psel && penable && pwrite;

   // writes to read-only words are dropped quietly; only an unmapped
   // address raises pslverr
   always_comb begin
      mapped      = 1'b1;
      next_prdata = 32'h0000_0000;
      case (paddr)
         OFS_DATA_POINTER_LOW:     next_prdata[7:0] = data_pointer_low;
         OFS_DATA_POINTER_HIGH:    next_prdata[7:0] = data_pointer_high;
         OFS_DATA_POINTER_PAGE:    next_prdata[7:0] = data_pointer_page;
         OFS_EXTERNAL_WAIT_CYCLES: next_prdata[7:0] = external_wait_cycles;
         OFS_CONTROL:    next_prdata[CTL_TIMER_RUN] = timer_run;
         OFS_WRITE_DATA: next_prdata[7:0] = write_byte;
         OFS_READ_DATA:  next_prdata[7:0] = read_byte;
         OFS_STATUS: begin
            next_prdata[STS_BUSY]    = seq_busy;
            next_prdata[STS_ALE]     = seq_ale;
            next_prdata[STS_LAST_WR] = last_write;
         end
         OFS_TIMER:      next_prdata[15:0] = timer_value;
         OFS_COMMAND:    next_prdata = 32'h0000_0000;
         default:        mapped = 1'b0;
      endcase
   end

   // read data and error are taken in the setup cycle so that both come
   // from flip-flops during the access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (setup) begin
         prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
         pslverr <= !mapped;
      end
   end

   // -------------------------------------------------------------------
   // software registers
   // -------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_pointer_low  <= RST_POINTER;
         data_pointer_high <= RST_POINTER;
         data_pointer_page <= RST_POINTER;
      end else if (wr_access) begin
         if (paddr == OFS_DATA_POINTER_LOW) begin
            data_pointer_low <= pwdata[7:0];
         end
         if (paddr == OFS_DATA_POINTER_HIGH) begin
            data_pointer_high <= pwdata[7:0];
         end
         if (paddr == OFS_DATA_POINTER_PAGE) begin
            data_pointer_page <= pwdata[7:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         external_wait_cycles <= RST_WAIT;
      end else if (wr_access && paddr == OFS_EXTERNAL_WAIT_CYCLES) begin
         external_wait_cycles <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_run  <= 1'b0;
         write_byte <= RST_BYTE;
      end else if (wr_access) begin
         if (paddr == OFS_CONTROL) begin
            timer_run <= pwdata[CTL_TIMER_RUN];
         end
         if (paddr == OFS_WRITE_DATA) begin
            write_byte <= pwdata[7:0];
         end
      end
   end

   // -------------------------------------------------------------------
   // instruction start
   // -------------------------------------------------------------------
   // a command written while an instruction runs is dropped; software
   // polls the busy flag before issuing the next one
   assign cmd_write = wr_access && paddr == OFS_COMMAND;
   assign start     = cmd_write && !seq_busy;
   assign gen_len   = {6'b000000, pwdata[CMD_LEN_LSB +: CMD_LEN_W]}
                      + 9'h001;

   always_comb begin
      if (pwdata[CMD_GENERIC]) begin
         start_len = gen_len;
      end else begin
         // wait count is sampled at the start; later writes do not
         // disturb an access already under way
         start_len = MOVE_BASE_CYCLES
                     + {1'b0, external_wait_cycles};
      end
   end

   // pointers are copied at the start, so software may set up the next
   // address while a move is still running
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         is_move    <= 1'b0;
         is_write   <= 1'b0;
         last_write <= 1'b0;
         addr_q     <= 24'h00_0000;
      end else if (start) begin
         is_move    <= !pwdata[CMD_GENERIC];
         is_write   <= pwdata[CMD_WRITE];
         last_write <= pwdata[CMD_WRITE] && !pwdata[CMD_GENERIC];
         if (!pwdata[CMD_GENERIC]) begin
            addr_q <= {data_pointer_page,
                       data_pointer_high,
                       data_pointer_low};
         end
      end
   end

   // every command runs the sequencer; generic ones only move the latch strobe
   xmp_cycle_seq u_seq (
      .pclk    (pclk),
      .presetn (presetn),
      .start   (start),
      .length  (start_len),
      .busy    (seq_busy),
      .count   (seq_count),
      .len     (seq_len),
      .ale     (seq_ale)
   );

   assign seq_last = seq_busy && (seq_count == seq_len - 9'h001);

   // -------------------------------------------------------------------
   // strobes and data drive
   // -------------------------------------------------------------------
   // only data moves reach the read and write strobes; there is no code fetch path;
   // the strobe ends a cycle early so the ram sees address and write
   // data still standing while it closes the access
   assign strobe_next = seq_busy && is_move
                        && (seq_count <= seq_len - 9'h003);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_n_q <= 1'b1;
         wr_n_q <= 1'b1;
      end else begin
         rd_n_q <= !(strobe_next && !is_write);
         wr_n_q <= !(strobe_next && is_write);
      end
   end

   // write data stands from the first strobe cycle until the last cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dout_q <= RST_BYTE;
         doe_q  <= 1'b0;
      end else begin
         dout_q <= write_byte;
         doe_q  <= seq_busy && is_move && is_write
                   && (seq_count <= seq_len - 9'h002);
      end
   end

   // -------------------------------------------------------------------
   // read capture
   // -------------------------------------------------------------------
   // bits are synchronised one by one; the byte is used only long after
   // the strobe fell, so all bits have settled by then
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xdata_meta <= 8'h00;
         xdata_sync <= 8'h00;
      end else begin
         xdata_meta <= xdata_in;
         xdata_sync <= xdata_meta;
      end
   end

   // two sync stages put the sampled pin value in the strobe window,
   // so the ram must hold data from two cycles before the end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         read_byte <= RST_BYTE;
      end else if (seq_last && is_move && !is_write) begin
         read_byte <= xdata_sync;
      end
   end

   // -------------------------------------------------------------------
   // timer
   // -------------------------------------------------------------------
   // a load written while the timer runs wins over the count step
   assign timer_load = wr_access && paddr == OFS_TIMER;

   xmp_tick_timer u_timer (
      .pclk       (pclk),
      .presetn    (presetn),
      .run        (timer_run),
      .load       (timer_load),
      .load_value (pwdata[15:0]),
      .value      (timer_value)
   );

   // -------------------------------------------------------------------
   // pin group
   // -------------------------------------------------------------------
   // every pin comes from a flip-flop, so no glitch reaches the ram
   assign xport.ale  = seq_ale;
   assign xport.rd_n = rd_n_q;
   assign xport.wr_n = wr_n_q;
   assign xport.addr = addr_q;
   assign xport.dout = dout_q;
   assign xport.doe  = doe_q;

endmodule : xmp_ext_mem_port

`default_nettype wire

// File: dv/xmp_ram_model.sv
// static ram on the far side of the external data-memory port
// assumes active-low strobes and a data bus split into in and out
`timescale 1ns/1ps
`default_nettype none

module xmp_ram_model
   import xmp_pkg::*;
#(
   parameter int DLY = 1
)(
   // port pins
   input  wire xmp_xport_type xport,
   output logic [7:0]         xdata
);
   logic [7:0] mem [logic [23:0]];
   logic [7:0] last = 8'h00;

   // a released bus shows the inverse of its last value, never a copy
   always @(xport.rd_n or xport.addr) begin
      if (xport.rd_n === 1'b0) begin
         last = mem.exists(xport.addr) ? mem[xport.addr] : 8'h00;
         xdata <= #DLY last;
      end else begin
         xdata <= #DLY ~last;
      end
   end

   // a write lands on the trailing edge of the write strobe
   always @(posedge xport.wr_n) begin
      if (xport.doe === 1'b1) begin
         mem[xport.addr] = xport.dout;
      end
   end
endmodule : xmp_ram_model
`default_nettype wire

// File: dv/xmp_ext_mem_port_sva.sv
// pin assertions for the external data-memory port
// assumes binding to xmp_ext_mem_port; sees only its ports
`timescale 1ns/1ps
`default_nettype none

module xmp_ext_mem_port_sva
   import xmp_pkg::*;
(
   // apb side
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       pwdata,
   // port side
   input wire xmp_xport_type     xport
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   logic       strb;
   logic [7:0] wait_sh;
   logic [8:0] strb_cnt;

   assign strb = !xport.rd_n || !xport.wr_n;

   // shadow of the wait register; moves are never overlapped by writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_sh <= 8'h00;
      end else if (psel && penable && pwrite
                   && paddr == OFS_EXTERNAL_WAIT_CYCLES) begin
         wait_sh <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strb_cnt <= 9'h000;
      end else begin
         strb_cnt <= strb ? strb_cnt + 9'h001 : 9'h000;
      end
   end

   sequence s_strb_start;
      $fell(xport.rd_n) || $fell(xport.wr_n);
   endsequence
   sequence s_ale_low3;
      !xport.ale [*3];
   endsequence

   a_one_strobe: assert property (xport.rd_n || xport.wr_n)
      else $error("read and write strobes low together");
   a_strobe_ale: assert property (strb |-> !xport.ale)
      else $error("latch strobe high beside a data strobe");
   a_fall_ale: assert property (s_strb_start |-> $fell(xport.ale))
      else $error("data strobe not in second move cycle");
   a_move_low: assert property (s_strb_start |-> s_ale_low3)
      else $error("latch strobe rose too early in a move");
   a_end_ale: assert property ($fell(strb) |=> $rose(xport.ale))
      else $error("move did not end one cycle after strobe");
   a_addr_hold: assert property (
      strb && $past(strb) |-> $stable(xport.addr))
      else $error("address moved under a strobe");
   a_doe_write: assert property (!xport.wr_n |-> xport.doe)
      else $error("write strobe without data drive");
   a_wait_len: assert property (
      $fell(strb) |-> strb_cnt == {1'b0, wait_sh} + 9'h002)
      else $error("strobe length does not match wait count");
endmodule : xmp_ext_mem_port_sva

bind xmp_ext_mem_port xmp_ext_mem_port_sva u_sva (
   .pclk    (pclk),
   .presetn (presetn),
   .psel    (psel),
   .penable (penable),
   .pwrite  (pwrite),
   .paddr   (paddr),
   .pwdata  (pwdata),
   .xport   (xport)
);
`default_nettype wire

// File: dv/test_xmp_ext_mem_port.sv
// self-checking bench for the external data-memory port
// assumes the ram model and checker are compiled before it
`timescale 1ns/1ps
`default_nettype none

module test_xmp_ext_mem_port
   import xmp_pkg::*;
();
   logic              pclk;
   logic              presetn;
   logic              psel;
   logic              penable;
   logic              pwrite;
   logic [ADDR_W-1:0] paddr;
   logic [31:0]       pwdata;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   xmp_xport_type     xport;
   logic [7:0]        xdata;
   int                num_errors;
   int                n_tests;
   logic [31:0]       rd;
   logic              err;
   int                ale_low;
   int                strb_low;
   logic [23:0]       seen_addr;

   xmp_ext_mem_port u_dut (
      .pclk     (pclk),
      .presetn  (presetn),
      .psel     (psel),
      .penable  (penable),
      .pwrite   (pwrite),
      .paddr    (paddr),
      .pwdata   (pwdata),
      .prdata   (prdata),
      .pready   (pready),
      .pslverr  (pslverr),
      .xport    (xport),
      .xdata_in (xdata)
   );
   xmp_ram_model #(.DLY(1)) u_ram (
      .xport (xport),
      .xdata (xdata)
   );

   initial begin
      pclk = 1'b0;
      forever begin
         #2 pclk = ~pclk;
      end
   end

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic stop_test();
      $display("checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : stop_test

   task automatic check(input string name, input logic [31:0] seen,
                        input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         num_errors++;
         stop_test();
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // counts latch-strobe-low and data-strobe cycles of one instruction
   task automatic measure();
      ale_low = 0;
      strb_low = 0;
      for (int i = 0; i < 40 && xport.ale !== 1'b0; i++) begin
         @(negedge pclk);
      end
      if (xport.ale !== 1'b0) begin
         num_errors++;
         stop_test();
      end
      seen_addr = xport.addr;
      while (xport.ale === 1'b0 && ale_low < 300) begin
         if (xport.rd_n === 1'b0 || xport.wr_n === 1'b0) begin
            strb_low++;
         end
         ale_low++;
         @(negedge pclk);
      end
   endtask : measure

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_regs();
      logic [ADDR_W-1:0] ofs [4];
      ofs = '{OFS_DATA_POINTER_LOW, OFS_DATA_POINTER_HIGH,
              OFS_DATA_POINTER_PAGE, OFS_EXTERNAL_WAIT_CYCLES};
      check("ale idle", {31'h0, xport.ale}, 32'h1);
      check("strobes idle", {30'h0, xport.rd_n, xport.wr_n}, 32'h3);
      foreach (ofs[i]) begin
         apb(1'b0, ofs[i], 32'h0);
         check("reset value", rd, 32'h0);
         apb(1'b1, ofs[i], 32'hffff_ff5a);
         apb(1'b0, ofs[i], 32'h0);
         check("byte register", rd, 32'h0000_005a);
      end
      apb(1'b0, 12'hffc, 32'h0);
      check("unmapped error", {31'h0, err}, 32'h1);
   endtask : t_regs

   task automatic t_move(input logic [7:0] pg, hi, lo, dt, nw);
      apb(1'b1, OFS_DATA_POINTER_PAGE, {24'h0, pg});
      apb(1'b1, OFS_DATA_POINTER_HIGH, {24'h0, hi});
      apb(1'b1, OFS_DATA_POINTER_LOW, {24'h0, lo});
      apb(1'b1, OFS_EXTERNAL_WAIT_CYCLES, {24'h0, nw});
      apb(1'b1, OFS_WRITE_DATA, {24'h0, dt});
      apb(1'b1, OFS_COMMAND, 32'h1);
      measure();
      check("move address", {8'h0, seen_addr}, {8'h0, pg, hi, lo});
      check("write ale low", ale_low, 32'h3 + nw);
      check("write strobe", strb_low, 32'h2 + nw);
      apb(1'b0, OFS_STATUS, 32'h0);
      check("status after write", rd, 32'h6);
      apb(1'b1, OFS_COMMAND, 32'h0);
      measure();
      check("read ale low", ale_low, 32'h3 + nw);
      apb(1'b0, OFS_STATUS, 32'h0);
      check("status after read", rd, 32'h2);
      apb(1'b0, OFS_READ_DATA, 32'h0);
      check("read data", rd, {24'h0, dt});
   endtask : t_move

   task automatic t_generic();
      for (int len = 2; len <= 8; len++) begin
         apb(1'b1, OFS_COMMAND, 32'h2 | (32'(len - 1) << CMD_LEN_LSB));
         measure();
         check("generic ale low", ale_low, 32'(len - 1));
         check("generic strobes", strb_low, 32'h0);
      end
      apb(1'b1, OFS_COMMAND, 32'h2);
      for (int i = 0; i < 8; i++) begin
         @(negedge pclk);
         check("single cycle ale", {31'h0, xport.ale}, 32'h1);
      end
   endtask : t_generic

   // two reads in a row take their setup edges three clocks apart
   task automatic t_timer();
      logic [31:0] t1;
      apb(1'b1, OFS_CONTROL, 32'h0);
      apb(1'b1, OFS_TIMER, 32'h0000_fffe);
      apb(1'b0, OFS_TIMER, 32'h0);
      check("timer load", rd, 32'h0000_fffe);
      apb(1'b1, OFS_CONTROL, 32'h1);
      apb(1'b0, OFS_TIMER, 32'h0);
      t1 = rd;
      apb(1'b0, OFS_TIMER, 32'h0);
      check("timer step", (rd - t1) & 32'h0000_ffff, 32'h3);
   endtask : t_timer

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = 32'h0;
      num_errors = 0;
      n_tests = 0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs();
      t_move(8'hff, 8'hff, 8'hff, 8'ha5, 8'h00);
      t_move(8'h00, 8'h00, 8'h00, 8'h3c, 8'h01);
      t_move(8'h12, 8'h34, 8'h56, 8'hc3, 8'h07);
      t_generic();
      t_timer();
      stop_test();
   end
endmodule : test_xmp_ext_mem_port
`default_nettype wire
